/* mac_mode_cfg.svh */
// constants for the mac mode-control register and the logic it steers
`ifndef MAC_MODE_CFG_SVH
`define MAC_MODE_CFG_SVH

// register fields: bit positions
`define MMC_GAP_LO        0
`define MMC_GAP_HI        1
`define MMC_DUPLEX        5
`define MMC_JUMBO         6
`define MMC_PAUSE         8
`define MMC_KEEP_CRC      9
`define MMC_QUEUE_LOOP    10
`define MMC_CORE_LOOP     11
`define MMC_RESET_VAL     16'h0000
// bits that hold storage; all others read zero
`define MMC_WRITE_MASK    16'h0f63

// oversize thresholds in bytes, destination address through fcs
`define OVERSIZE_STD      13'h05ea
`define OVERSIZE_JUMBO    13'h118b
`define RX_COUNT_MAX      13'h1fff

// timing: clock period and bit time in ns
`define CLK_PERIOD_NS     40
`define BIT_TIME_NS       10
// spacing after a collision, in bit times: base plus step per select value
`define GAP_BASE_BITS     96
`define GAP_STEP_BITS     32
// one pause quantum is 512 bit times
`define PAUSE_QUANTUM_NS  5120
`define PAUSE_QUANTUM_CYC (`PAUSE_QUANTUM_NS / `CLK_PERIOD_NS)

`endif

/* mac_mode_pkg.sv */
// types shared by the mac mode-control block
package mac_mode_pkg;

	// one byte moving between mac and fifo
	typedef struct packed {
		logic       vld;
		logic       last;
		logic [7:0] data;
	} beat_t;

	// field view of the stored register
	typedef struct packed {
		logic [1:0] min_gap_select;
		logic       duplex_full_on;
		logic       jumbo_accept_size;
		logic       pause_honor_on;
		logic       keep_crc_field;
		logic       queue_loopback;
		logic       core_loopback;
	} mode_t;

endpackage

/* mac_mode_control.sv */
// mac mode-control register and the transmit, receive and loopback behaviour it selects
// Contract
// - bits 1:0 choose minimum bit-time spacing while deferring after a collision, half duplex.
// - larger spacing values make the transmitter wait longer before contending.
// - full-duplex bit 5 stops transmit deference to receive activity.
// - in full duplex carrier-sense error counting is suppressed.
// - a new duplex setting applies only after both path resets were asserted.
// - bit 6 clear flags frames of 1514 bytes up; set raises it to 4491.
// - counted length covers addresses, type/length field and the fcs.
// - bit 8 clear treats all frames as data; set acts on pause frames.
// - bit 9 set passes the fcs to the host; clear strips it (here bit 9 only drives keep_crc_field; rx_fifo_in carries every byte).
// - every received fcs is checked and errors reported regardless of bit 9.
// - bit 10 routes transmit fifo data straight into the receive fifo.
// - bit 11 routes the mac transmit interface back into mac receive.
// - bits 4:2, 7 and 15:12 are reserved without function.
// - an acted-on pause halts transmit for its duration and shows paused.
`timescale 1ns/1ps
`include "mac_mode_cfg.svh"

module mac_mode_control (
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	input  wire logic                reg_wr,
	input  wire logic [15:0]         reg_wdata,
	output logic      [15:0]         reg_rdata,
	input  wire logic                transmit_path_reset,
	input  wire logic                receive_path_reset,
	input  wire logic                crs_pin,
	input  wire logic                collision_defer,
	input  wire logic                carrier_loss_event,
	output logic                     carrier_loss_count,
	input  wire logic                pause_seen,
	input  wire logic [15:0]         pause_quanta,
	output logic                     paused,
	output logic                     tx_may_start,
	input  wire mac_mode_pkg::beat_t rx_mac_in,
	input  wire logic                rx_fcs_bad,
	output logic                     oversize_flag,
	output logic                     fcs_error,
	output logic                     keep_crc_field,
	input  wire mac_mode_pkg::beat_t mac_tx_out,
	input  wire mac_mode_pkg::beat_t tx_fifo_out,
	output mac_mode_pkg::beat_t      rx_fifo_in
);

	mac_mode_pkg::mode_t mode;
	logic [15:0] ctrl_q, ctrl_d;
	logic        duplex_eff_q, duplex_eff_d;
	logic        tx_seen_q, tx_seen_d, rx_seen_q, rx_seen_d;
	logic        crs_m_q, crs_s_q;
	logic [7:0]  gap_q, gap_d;
	logic [22:0] pause_q, pause_d;
	logic [12:0] cnt_q, cnt_d, cnt_next;
	logic        over_q, over_d, fcs_q, fcs_d, cle_q, cle_d;
	mac_mode_pkg::beat_t rx_sel, rxo_q;
	logic        apply;
	int          gap_bits;

	// field view of the stored word
	always_comb begin
		mode.min_gap_select    = ctrl_q[`MMC_GAP_HI:`MMC_GAP_LO];
		mode.duplex_full_on    = ctrl_q[`MMC_DUPLEX];
		mode.jumbo_accept_size = ctrl_q[`MMC_JUMBO];
		mode.pause_honor_on    = ctrl_q[`MMC_PAUSE];
		mode.keep_crc_field    = ctrl_q[`MMC_KEEP_CRC];
		mode.queue_loopback    = ctrl_q[`MMC_QUEUE_LOOP];
		mode.core_loopback     = ctrl_q[`MMC_CORE_LOOP];
	end

	// reserved bits never store, so they read zero
	assign reg_rdata      = ctrl_q;
	assign keep_crc_field = mode.keep_crc_field;
	assign apply          = (tx_seen_q | transmit_path_reset) & (rx_seen_q | receive_path_reset);

	// control register and delayed duplex setting
	always_comb begin
		ctrl_d       = reg_wr ? (reg_wdata & `MMC_WRITE_MASK) : ctrl_q;
		// a reset seen in the write cycle still counts: set beats clear
		tx_seen_d    = transmit_path_reset | (tx_seen_q & ~reg_wr & ~apply);
		rx_seen_d    = receive_path_reset | (rx_seen_q & ~reg_wr & ~apply);
		if (apply) begin
			tx_seen_d = 1'b0;
			rx_seen_d = 1'b0;
		end
		duplex_eff_d = apply ? mode.duplex_full_on : duplex_eff_q;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q       <= `MMC_RESET_VAL;
			duplex_eff_q <= 1'b0;
			tx_seen_q    <= 1'b0;
			rx_seen_q    <= 1'b0;
		end else begin
			ctrl_q       <= ctrl_d;
			duplex_eff_q <= duplex_eff_d;
			tx_seen_q    <= tx_seen_d;
			rx_seen_q    <= rx_seen_d;
		end
	end

	// carrier sense arrives from the pin, so two flops before any use
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			crs_m_q <= 1'b0;
			crs_s_q <= 1'b0;
		end else begin
			crs_m_q <= crs_pin;
			crs_s_q <= crs_m_q;
		end
	end

	// transmit timing: collision spacing, pause halt, receive deference
	always_comb begin
		gap_bits = `GAP_BASE_BITS + int'(mode.min_gap_select) * `GAP_STEP_BITS;
		gap_d    = (gap_q != 8'h00) ? gap_q - 8'h01 : 8'h00;
		// spacing only matters when sharing the medium
		if (collision_defer && !duplex_eff_q)
			gap_d = 8'((gap_bits * `BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
		pause_d  = (pause_q != 23'h000000) ? pause_q - 23'h000001 : 23'h000000;
		// with flow control off the pause frame is just data
		if (pause_seen && mode.pause_honor_on)
			pause_d = 23'(pause_quanta) * 23'(`PAUSE_QUANTUM_CYC);
		cle_d    = carrier_loss_event & ~duplex_eff_q;
	end

	assign paused       = (pause_q != 23'h000000);
	// full duplex ignores carrier, half duplex defers to it
	assign tx_may_start = (gap_q == 8'h00) & ~paused & (duplex_eff_q | ~crs_s_q);
	assign carrier_loss_count = cle_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_q   <= 8'h00;
			pause_q <= 23'h000000;
			cle_q   <= 1'b0;
		end else begin
			gap_q   <= gap_d;
			pause_q <= pause_d;
			cle_q   <= cle_d;
		end
	end

	// receive path: loopback select, length count, oversize and fcs report
	always_comb begin
		rx_sel = rx_mac_in;
		if (mode.core_loopback)
			rx_sel = mac_tx_out;
		// fifo loopback bypasses the mac entirely, so it wins
		if (mode.queue_loopback)
			rx_sel = tx_fifo_out;
		cnt_next = (cnt_q == `RX_COUNT_MAX) ? cnt_q : cnt_q + 13'h0001;
		cnt_d    = cnt_q;
		over_d   = 1'b0;
		fcs_d    = 1'b0;
		if (rx_sel.vld) begin
			cnt_d = rx_sel.last ? 13'h0000 : cnt_next;
			if (rx_sel.last) begin
				over_d = cnt_next >= (mode.jumbo_accept_size ?
					`OVERSIZE_JUMBO : `OVERSIZE_STD);
				fcs_d  = rx_fcs_bad;
			end
		end
	end

	assign oversize_flag = over_q;
	assign fcs_error     = fcs_q;
	assign rx_fifo_in    = rxo_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q  <= 13'h0000;
			over_q <= 1'b0;
			fcs_q  <= 1'b0;
			rxo_q  <= '0;
		end else begin
			cnt_q  <= cnt_d;
			over_q <= over_d;
			fcs_q  <= fcs_d;
			rxo_q  <= rx_sel;
		end
	end

	a_reserved_read_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_rdata & ~`MMC_WRITE_MASK) == 16'h0000)
		else $error("reserved bits read nonzero");

	a_reset_clears_reg: assert property (@(posedge core_clk)
		!rst_b |-> reg_rdata == 16'h0000)
		else $error("register not zero in reset");

	a_duplex_needs_resets: assert property (@(posedge core_clk) disable iff (!rst_b)
		$changed(duplex_eff_q) |-> $past(apply) && duplex_eff_q == $past(mode.duplex_full_on))
		else $error("duplex changed without both path resets");

	a_full_no_defer: assert property (@(posedge core_clk) disable iff (!rst_b)
		duplex_eff_q && !paused && gap_q == 8'h00 |-> tx_may_start)
		else $error("full duplex still defers");

	a_half_defers_crs: assert property (@(posedge core_clk) disable iff (!rst_b)
		!duplex_eff_q && crs_s_q |-> !tx_may_start)
		else $error("half duplex ignored carrier");

	a_carrier_count_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		carrier_loss_count |-> !$past(duplex_eff_q) && $past(carrier_loss_event))
		else $error("carrier error counted in full duplex");

	a_gap_after_collision: assert property (@(posedge core_clk) disable iff (!rst_b)
		collision_defer && !duplex_eff_q && mode.min_gap_select == 2'h0
		|=> !tx_may_start [*8] ##16 (gap_q == 8'h01) ##1 (gap_q == 8'h00))
		else $error("collision spacing wrong length");

	a_pause_honored: assert property (@(posedge core_clk) disable iff (!rst_b)
		pause_seen && mode.pause_honor_on && pause_quanta == 16'h0001
		|=> paused [*8] ##120 paused ##1 !paused)
		else $error("pause not held for its quanta");

	a_pause_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
		pause_seen && !mode.pause_honor_on && !paused |=> !paused)
		else $error("pause acted on with flow control off");

	a_oversize_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_sel.vld && rx_sel.last && !mode.jumbo_accept_size && cnt_q == 13'h05e9
		|=> oversize_flag)
		else $error("1514 byte frame not flagged");

	a_fcs_always_checked: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_sel.vld && rx_sel.last && rx_fcs_bad |=> fcs_error)
		else $error("fcs error not reported");

	a_queue_loopback: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode.queue_loopback |=> rx_fifo_in == $past(tx_fifo_out))
		else $error("fifo loopback data lost");

	c_duplex_applied: cover property (@(posedge core_clk) disable iff (!rst_b)
		apply && mode.duplex_full_on && !duplex_eff_q);
	c_pause_halt: cover property (@(posedge core_clk) disable iff (!rst_b)
		$rose(paused));
	c_jumbo_oversize: cover property (@(posedge core_clk) disable iff (!rst_b)
		oversize_flag && mode.jumbo_accept_size);
	c_core_loopback: cover property (@(posedge core_clk) disable iff (!rst_b)
		mode.core_loopback && mac_tx_out.vld);

endmodule // mac_mode_control

/* mac_mode_control_tb.sv */
// self-checking bench for the mac mode-control register block
`timescale 1ns/1ps

module mac_mode_control_tb;
	logic                core_clk, rst_b, reg_wr, crs_pin, collision_defer, rx_fcs_bad;
	logic                transmit_path_reset, receive_path_reset, carrier_loss_event;
	logic                carrier_loss_count, pause_seen, paused, tx_may_start;
	logic                oversize_flag, fcs_error, keep_crc_field;
	logic [15:0]         reg_wdata, reg_rdata, pause_quanta;
	mac_mode_pkg::beat_t rx_mac_in, mac_tx_out, tx_fifo_out, rx_fifo_in;
	int                  n_errors, num_checks, cycles, c;

	mac_mode_control mac_mode_control_i (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .transmit_path_reset(transmit_path_reset),
		.receive_path_reset(receive_path_reset), .crs_pin(crs_pin),
		.collision_defer(collision_defer), .carrier_loss_event(carrier_loss_event),
		.carrier_loss_count(carrier_loss_count), .pause_seen(pause_seen),
		.pause_quanta(pause_quanta), .paused(paused), .tx_may_start(tx_may_start),
		.rx_mac_in(rx_mac_in), .rx_fcs_bad(rx_fcs_bad), .oversize_flag(oversize_flag),
		.fcs_error(fcs_error), .keep_crc_field(keep_crc_field), .mac_tx_out(mac_tx_out),
		.tx_fifo_out(tx_fifo_out), .rx_fifo_in(rx_fifo_in));

	// 25 mhz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// hang guard: all tests need well under this many cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one write; both path resets follow only when asked, so duplex changes can be held back
	task automatic wr(input logic [15:0] v, input bit rst_paths);
		@(posedge core_clk) {reg_wr, reg_wdata} <= {1'b1, v};
		@(posedge core_clk) reg_wr <= 1'b0;
		if (rst_paths) begin
			{transmit_path_reset, receive_path_reset} <= 2'b11;
			@(posedge core_clk) {transmit_path_reset, receive_path_reset} <= 2'b00;
		end
		repeat (2) @(posedge core_clk);
	endtask

	task automatic count_hi(ref logic s, input int n, output int k);
		k = 0;
		repeat (n) begin
			@(negedge core_clk);
			if (s === 1'b1) k++;
		end
	endtask

	task automatic t_reg();
		@(negedge core_clk) chk(reg_rdata, 16'h0000);
		wr(16'hffff, 0);
		@(negedge core_clk) chk(reg_rdata, 16'h0f63);
		// a reset in mid-run must clear every stored bit again
		@(posedge core_clk) rst_b <= 1'b0;
		@(negedge core_clk) chk(reg_rdata, 16'h0000);
		@(posedge core_clk) rst_b <= 1'b1;
		wr(16'h0000, 1);
		$display("register test done");
	endtask

	// collision spacing per select value, then full duplex ignores collisions
	task automatic t_gap();
		for (int s = 0; s < 6; s++) begin
			if (s < 4) wr(16'(s), 1);
			if (s == 4) wr(16'h0020, 1);
			if (s == 5) wr(16'h0000, 0);
			@(posedge core_clk) collision_defer <= 1'b1;
			@(posedge core_clk) collision_defer <= 1'b0;
			count_hi(tx_may_start, 60, c);
			chk(16'(60 - c), (s < 4) ? 16'(24 + 8 * s) : 16'h0000);
		end
		for (int s = 0; s < 2; s++) begin
			wr(s ? 16'h0020 : 16'h0000, 1);
			@(posedge core_clk) carrier_loss_event <= 1'b1;
			@(posedge core_clk) carrier_loss_event <= 1'b0;
			count_hi(carrier_loss_count, 4, c);
			chk(16'(c), s ? 16'h0000 : 16'h0001);
		end
		// carrier on the pin: half duplex defers once the two sync flops pass it
		for (int s = 0; s < 2; s++) begin
			wr(s ? 16'h0000 : 16'h0020, 1);
			@(posedge core_clk) crs_pin <= 1'b1;
			count_hi(tx_may_start, 4, c);
			@(posedge core_clk) crs_pin <= 1'b0;
			chk(16'(c), s ? 16'h0002 : 16'h0004);
		end
		$display("gap test done");
	endtask

	task automatic t_pause();
		for (int s = 0; s < 2; s++) begin
			wr(s ? 16'h0120 : 16'h0000, 1);
			@(posedge core_clk) {pause_seen, pause_quanta} <= {1'b1, 16'h0001};
			@(posedge core_clk) pause_seen <= 1'b0;
			count_hi(paused, 140, c);
			chk(16'(c), s ? 16'h0080 : 16'h0000);
		end
		$display("pause test done");
	endtask

	// lengths either side of both thresholds, fcs bad on exactly the frames that keep it
	task automatic t_frame();
		int len[4] = '{1513, 1514, 4490, 4491};
		int ov;
		int fe;
		for (int f = 0; f < 4; f++) begin
			// keep-fcs only changes between frames, with the receive path reset
			wr({6'h00, f[0], 2'b00, f[1], 6'h00}, 1);
			@(negedge core_clk) chk(16'(keep_crc_field), 16'(f[0]));
			for (int i = 0; i < len[f]; i++)
				@(posedge core_clk) rx_mac_in <= {1'b1, i == len[f] - 1, i[7:0]};
			rx_fcs_bad <= f[0];
			@(posedge core_clk) rx_mac_in <= '0;
			rx_fcs_bad <= 1'b0;
			ov = 0;
			fe = 0;
			// both flags pulse in the same cycle, so one pass must count them together
			repeat (3) @(negedge core_clk) begin
				if (oversize_flag === 1'b1) ov++;
				if (fcs_error === 1'b1) fe++;
			end
			chk(16'(ov), 16'(f[0]));
			chk(16'(fe), 16'(f[0]));
		end
		$display("frame test done");
	endtask

	// each source offers a different byte; only the selected one may reach the fifo
	task automatic t_loop();
		logic [15:0] mv[4] = '{16'h0000, 16'h0800, 16'h0400, 16'h0020};
		logic [7:0] exp[4] = '{8'h3c, 8'ha5, 8'h5a, 8'h3c};
		logic [7:0] got;
		for (int m = 0; m < 4; m++) begin
			// path resets after every loopback change; the last mode is the cable setup
			wr(mv[m], 1);
			@(posedge core_clk) rx_mac_in <= {2'b11, 8'h3c};
			mac_tx_out <= {2'b11, 8'ha5};
			// only one single-beat frame ever stands in the transmit fifo
			tx_fifo_out <= {2'b11, 8'h5a};
			@(posedge core_clk) {rx_mac_in, mac_tx_out, tx_fifo_out} <= '0;
			got = 8'h00;
			repeat (3) @(negedge core_clk) if (rx_fifo_in.vld === 1'b1) got = rx_fifo_in.data;
			chk(16'(got), 16'(exp[m]));
		end
		$display("loopback test done");
	endtask

	// reset for four cycles, then the tests in turn
	initial begin
		{rst_b, reg_wr, crs_pin, collision_defer, rx_fcs_bad, pause_seen} = '0;
		{transmit_path_reset, receive_path_reset, carrier_loss_event} = '0;
		{reg_wdata, pause_quanta, rx_mac_in, mac_tx_out, tx_fifo_out} = '0;
		{n_errors, num_checks, cycles} = '0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reg();
		t_gap();
		t_pause();
		t_frame();
		t_loop();
		give_verdict();
	end
endmodule // mac_mode_control_tb
